// ===== opc_pkg.sv
// Constants and types shared by the operating conditions object bank
// How it works
// (R1) Entry one reports power rail millivolts, signed
// (R2) Entry two reports logic rail millivolts, signed
// (R3) Entry three reports board temperature, tenth degrees
// (R4) Entry four reports motor temperature, reserved content
// (R5) Entry five reports chip temperature, reserved content
// (R6) Telemetry entries refuse every write
// (R7) Mode enable byte is writable, resets zero
// (R8) Virtual switch byte is writable, resets zero
// (R9) Enable zero turns modes off, two on
// (R10) Virtual switch selects the special mode used
// (R11) Entries refresh from each new measurement
package opc_pkg;

   // ----------------------------------------------------------------
   // Object addresses
   // ----------------------------------------------------------------
   localparam logic [15:0] OPC_IDX_CONDITIONS = 16'h4014;
   localparam logic [15:0] OPC_IDX_DRIVE_MODES = 16'h4015;

   localparam logic [7:0] OPC_SUB_COUNT = 8'h00;
   localparam logic [7:0] OPC_SUB_POWER = 8'h01;
   localparam logic [7:0] OPC_SUB_LOGIC = 8'h02;
   localparam logic [7:0] OPC_SUB_BOARD = 8'h03;
   localparam logic [7:0] OPC_SUB_MOTOR = 8'h04;
   localparam logic [7:0] OPC_SUB_CHIP = 8'h05;
   localparam logic [7:0] OPC_SUB_MODE_ENABLE = 8'h01;
   localparam logic [7:0] OPC_SUB_SWITCH = 8'h02;

   // ----------------------------------------------------------------
   // Reset and fixed values
   // ----------------------------------------------------------------
   localparam int OPC_TELEMETRY_ENTRIES = 5;
   localparam logic [7:0] OPC_TELEMETRY_COUNT = 8'h05;
   localparam logic [7:0] OPC_DRIVE_MODE_COUNT = 8'h02;
   localparam logic [7:0] OPC_MODE_ENABLE_RESET = 8'h00;
   localparam logic [7:0] OPC_SWITCH_RESET = 8'h00;
   localparam logic [31:0] OPC_TELEMETRY_RESET = 32'h0000_0000;
   localparam logic [7:0] OPC_MODE_OFF = 8'h00;
   localparam logic [7:0] OPC_MODE_ON = 8'h02;

   // Answer sizes in bytes
   localparam logic [2:0] OPC_SIZE_BYTE = 3'h1;
   localparam logic [2:0] OPC_SIZE_WORD = 3'h4;

   // ----------------------------------------------------------------
   // Standard CANopen abort codes
   // ----------------------------------------------------------------
   localparam logic [31:0] OPC_ABORT_NONE = 32'h0000_0000;
   localparam logic [31:0] OPC_ABORT_READ_ONLY = 32'h0601_0002;
   localparam logic [31:0] OPC_ABORT_NO_OBJECT = 32'h0602_0000;
   localparam logic [31:0] OPC_ABORT_NO_SUBINDEX = 32'h0609_0011;

   // ----------------------------------------------------------------
   // Access sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      OPC_ST_IDLE = 2'b01,
      OPC_ST_ANSWER = 2'b10
   } opc_state_t;

endpackage

// ===== opc_sample_hold.sv
// Holds one telemetry measurement, refreshed on each new sample
`timescale 1ns/1ns
module opc_sample_hold
   import opc_pkg::*;
#(
   parameter int WIDTH = 32
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   // New measurement
   input wire logic sample_valid_in,
   input wire logic [WIDTH-1:0] sample_in,
   // Held value
   output logic [WIDTH-1:0] value_out
);

   // Take each new measurement as it arrives
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         value_out <= OPC_TELEMETRY_RESET[WIDTH-1:0];
      end else if (sample_valid_in) begin
         value_out <= sample_in; // [R11]
      end
   end

endmodule

// ===== opc_mode_decode.sv
// Turns the drive mode enable and switch bytes into mode controls
`timescale 1ns/1ns
module opc_mode_decode
   import opc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   // Stored configuration
   input wire logic [7:0] mode_enable_in,
   input wire logic [7:0] switch_value_in,
   // Decoded controls
   output logic modes_on_out,
   output logic [7:0] mode_select_out
);

   // Only the enable code two switches the modes on; all else is off
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         modes_on_out <= 1'b0;
         mode_select_out <= OPC_SWITCH_RESET;
      end else begin
         modes_on_out <= (mode_enable_in == OPC_MODE_ON); // [R9]
         // Selector is only passed on while the modes are on
         if (mode_enable_in == OPC_MODE_ON) begin
            mode_select_out <= switch_value_in; // [R10]
         end else begin
            mode_select_out <= OPC_SWITCH_RESET;
         end
      end
   end

endmodule

// ===== opc_object_bank.sv
// Operating conditions and special drive mode object bank
`timescale 1ns/1ns
module opc_object_bank
   import opc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   // Object access request from the fieldbus protocol engine
   input wire logic req_in,
   input wire logic write_in,
   input wire logic [15:0] index_in,
   input wire logic [7:0] subindex_in,
   input wire logic [31:0] wdata_in,
   // Object access answer
   output logic ack_out,
   output logic [31:0] rdata_out,
   output logic [2:0] size_out,
   output logic abort_out,
   output logic [31:0] abort_code_out,
   // Measurements from the converters, one strobe per entry
   input wire logic [OPC_TELEMETRY_ENTRIES-1:0] sample_valid_in,
   input wire logic [31:0] power_supply_rail_mv_in,
   input wire logic [31:0] logic_supply_rail_mv_in,
   input wire logic [31:0] control_board_temp_in,
   input wire logic [31:0] motor_temp_in,
   input wire logic [31:0] chip_temp_in,
   // Special drive mode controls
   output logic special_modes_on_out,
   output logic [7:0] drive_mode_select_out,
   output logic [7:0] drive_mode_enable_out,
   output logic [7:0] virtual_switch_value_out
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   opc_state_t state;
   opc_state_t next_state;
   logic [31:0] sample_bus [OPC_TELEMETRY_ENTRIES];
   logic [31:0] telemetry [OPC_TELEMETRY_ENTRIES];
   logic [7:0] drive_mode_enable;
   logic [7:0] virtual_switch_value;
   logic take;
   logic hit_conditions;
   logic hit_modes;
   logic [31:0] next_rdata;
   logic [2:0] next_size;
   logic [31:0] next_abort_code;
   logic wr_enable;
   logic wr_switch;

   // Byte value widened into the answer word
   function automatic logic [31:0] opc_widen(input logic [7:0] b);
      return {24'h00_0000, b};
   endfunction

   // ----------------------------------------------------------------
   // Telemetry entries
   // ----------------------------------------------------------------
   assign sample_bus[0] = power_supply_rail_mv_in; // [R1]
   assign sample_bus[1] = logic_supply_rail_mv_in; // [R2]
   assign sample_bus[2] = control_board_temp_in; // [R3]
   assign sample_bus[3] = motor_temp_in; // [R4]
   assign sample_bus[4] = chip_temp_in; // [R5]

   // One holder per entry, refreshed on every new measurement
   for (genvar g = 0; g < OPC_TELEMETRY_ENTRIES; g++) begin : g_entry
      opc_sample_hold #(
         .WIDTH(32)
      ) u_hold (
         .sys_clk_in(sys_clk_in),
         .resetn_in(resetn_in),
         .sample_valid_in(sample_valid_in[g]),
         .sample_in(sample_bus[g]),
         .value_out(telemetry[g])
      );
   end

   // ----------------------------------------------------------------
   // Request decode
   // ----------------------------------------------------------------
   // A request is taken only while idle; one arriving during the
   // answer cycle is ignored and must be repeated
   assign take = req_in && (state == OPC_ST_IDLE);
   assign hit_conditions = (index_in == OPC_IDX_CONDITIONS);
   assign hit_modes = (index_in == OPC_IDX_DRIVE_MODES);
   assign wr_enable = take && write_in && hit_modes
      && (subindex_in == OPC_SUB_MODE_ENABLE);
   assign wr_switch = take && write_in && hit_modes
      && (subindex_in == OPC_SUB_SWITCH);

   // Answer data, size and abort code for the request in hand
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_size = OPC_SIZE_BYTE;
      next_abort_code = OPC_ABORT_NONE;
      if (hit_conditions) begin
         unique case (subindex_in)
            OPC_SUB_COUNT: begin
               next_rdata = opc_widen(OPC_TELEMETRY_COUNT);
            end
            OPC_SUB_POWER: begin
               next_rdata = telemetry[0]; // [R1]
               next_size = OPC_SIZE_WORD;
            end
            OPC_SUB_LOGIC: begin
               next_rdata = telemetry[1]; // [R2]
               next_size = OPC_SIZE_WORD;
            end
            OPC_SUB_BOARD: begin
               next_rdata = telemetry[2]; // [R3]
               next_size = OPC_SIZE_WORD;
            end
            OPC_SUB_MOTOR: begin
               next_rdata = telemetry[3]; // [R4]
               next_size = OPC_SIZE_WORD;
            end
            OPC_SUB_CHIP: begin
               next_rdata = telemetry[4]; // [R5]
               next_size = OPC_SIZE_WORD;
            end
            default: begin
               next_abort_code = OPC_ABORT_NO_SUBINDEX;
            end
         endcase
         // Every telemetry subindex, count included, refuses writes
         if (write_in && (next_abort_code == OPC_ABORT_NONE)) begin
            next_abort_code = OPC_ABORT_READ_ONLY; // [R6]
         end
      end else if (hit_modes) begin
         unique case (subindex_in)
            OPC_SUB_COUNT: begin
               next_rdata = opc_widen(OPC_DRIVE_MODE_COUNT);
               if (write_in) begin
                  next_abort_code = OPC_ABORT_READ_ONLY;
               end
            end
            OPC_SUB_MODE_ENABLE: begin
               next_rdata = opc_widen(drive_mode_enable); // [R7]
            end
            OPC_SUB_SWITCH: begin
               next_rdata = opc_widen(virtual_switch_value); // [R8]
            end
            default: begin
               next_abort_code = OPC_ABORT_NO_SUBINDEX;
            end
         endcase
      end else begin
         next_abort_code = OPC_ABORT_NO_OBJECT;
      end
      // Writes and refused accesses return no data
      if (write_in || (next_abort_code != OPC_ABORT_NONE)) begin
         next_rdata = 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Access sequencer
   // ----------------------------------------------------------------
   // Idle takes a request, the answer stands one cycle, then idle
   always_comb begin
      next_state = state;
      unique case (state)
         OPC_ST_IDLE: begin
            if (req_in) begin
               next_state = OPC_ST_ANSWER;
            end
         end
         OPC_ST_ANSWER: begin
            next_state = OPC_ST_IDLE;
         end
         default: begin
            next_state = OPC_ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state <= OPC_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Answer registers, loaded when a request is taken
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_out <= 32'h0000_0000;
         size_out <= OPC_SIZE_BYTE;
         abort_code_out <= OPC_ABORT_NONE;
         abort_out <= 1'b0;
      end else if (take) begin
         rdata_out <= next_rdata;
         size_out <= next_size;
         abort_code_out <= next_abort_code;
         abort_out <= (next_abort_code != OPC_ABORT_NONE);
      end
   end

   // Answer strobe marks the cycle after the request was taken
   assign ack_out = (state == OPC_ST_ANSWER);

   // ----------------------------------------------------------------
   // Drive mode configuration
   // ----------------------------------------------------------------
   // Mode enable byte; low byte of the written word is kept
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         drive_mode_enable <= OPC_MODE_ENABLE_RESET; // [R7]
      end else if (wr_enable) begin
         drive_mode_enable <= wdata_in[7:0]; // [R7]
      end
   end

   // Virtual configuration switch byte
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         virtual_switch_value <= OPC_SWITCH_RESET; // [R8]
      end else if (wr_switch) begin
         virtual_switch_value <= wdata_in[7:0]; // [R8]
      end
   end

   assign drive_mode_enable_out = drive_mode_enable;
   assign virtual_switch_value_out = virtual_switch_value;

   // Decode enable and switch into the mode controls
   opc_mode_decode u_mode (
      .sys_clk_in(sys_clk_in),
      .resetn_in(resetn_in),
      .mode_enable_in(drive_mode_enable),
      .switch_value_in(virtual_switch_value),
      .modes_on_out(special_modes_on_out),
      .mode_select_out(drive_mode_select_out)
   );

endmodule

// ===== opc_master_model.sv
// Fieldbus master model issuing object accesses
`timescale 1ns/1ns
module opc_master_model (
   // Clock and answer
   input wire logic sys_clk_in,
   input wire logic ack_in,
   // Request
   output logic req_out,
   output logic write_out,
   output logic [15:0] index_out,
   output logic [7:0] sub_out,
   output logic [31:0] wdata_out
);
   initial begin
      req_out = 1'b0;
      write_out = 1'b0;
      index_out = 16'h0000;
      sub_out = 8'h00;
      wdata_out = 32'h0000_0000;
   end
   // Hold the request up to the answer, then scramble the released lines
   task automatic access(input logic w, input logic [15:0] i,
                         input logic [7:0] s, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk_in);
      req_out <= 1'b1;
      write_out <= w;
      index_out <= i;
      sub_out <= s;
      wdata_out <= d;
      do begin
         @(negedge sys_clk_in);
         n++;
      end while (!ack_in && n < 8);
      @(posedge sys_clk_in);
      req_out <= 1'b0;
      write_out <= ~w;
      index_out <= ~i;
      sub_out <= ~s;
      wdata_out <= ~d;
   endtask
endmodule

// ===== opc_object_bank_checker.sv
// Port checks for the object bank
`timescale 1ns/1ns
module opc_object_bank_checker
   import opc_pkg::*;
(
   // Clock, reset, request
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic req_in,
   input wire logic write_in,
   input wire logic [15:0] index_in,
   input wire logic [7:0] subindex_in,
   input wire logic [31:0] wdata_in,
   // Answer and measurements
   input wire logic ack_out,
   input wire logic [31:0] rdata_out,
   input wire logic abort_out,
   input wire logic [31:0] abort_code_out,
   input wire logic [OPC_TELEMETRY_ENTRIES-1:0] sample_valid_in,
   input wire logic [31:0] power_supply_rail_mv_in,
   input wire logic [31:0] logic_supply_rail_mv_in,
   input wire logic [31:0] control_board_temp_in,
   // Mode controls
   input wire logic special_modes_on_out,
   input wire logic [7:0] drive_mode_select_out,
   input wire logic [7:0] drive_mode_enable_out,
   input wire logic [7:0] virtual_switch_value_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);
   logic [31:0] held [3];
   wire logic take = req_in && !ack_out;
   wire logic rd_tel = take && !write_in && index_in == OPC_IDX_CONDITIONS;
   wire logic wr_mod = take && write_in && index_in == OPC_IDX_DRIVE_MODES;
   // Mirror of the first three measured entries (power, logic, board)
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         held <= '{default: 32'h0};
      end else begin
         if (sample_valid_in[0]) held[0] <= power_supply_rail_mv_in;
         if (sample_valid_in[1]) held[1] <= logic_supply_rail_mv_in;
         if (sample_valid_in[2]) held[2] <= control_board_temp_in;
      end
   end
   ack_pulse_a: assert property (take |=> ack_out ##1 !ack_out)
      else $error("answer strobe timing wrong");
   power_read_a: assert property (rd_tel && subindex_in == 8'h01
      |=> rdata_out == $past(held[0])) else $error("power entry wrong");
   logic_read_a: assert property (rd_tel && subindex_in == 8'h02
      |=> rdata_out == $past(held[1])) else $error("logic entry wrong");
   board_read_a: assert property (rd_tel && subindex_in == 8'h03
      |=> rdata_out == $past(held[2])) else $error("board entry wrong");
   tel_readonly_a: assert property (take && write_in &&
      index_in == OPC_IDX_CONDITIONS && subindex_in <= OPC_SUB_CHIP
      |=> abort_out && abort_code_out == OPC_ABORT_READ_ONLY)
      else $error("write not refused");
   enable_write_a: assert property (wr_mod && subindex_in == 8'h01
      |=> drive_mode_enable_out == $past(wdata_in[7:0]))
      else $error("enable not stored");
   switch_write_a: assert property (wr_mod && subindex_in == 8'h02
      |=> virtual_switch_value_out == $past(wdata_in[7:0]))
      else $error("switch not stored");
   modes_on_a: assert property (special_modes_on_out ==
      ($past(drive_mode_enable_out) == OPC_MODE_ON)) else $error("modes on");
   mode_select_a: assert property (drive_mode_select_out ==
      ($past(drive_mode_enable_out) == OPC_MODE_ON ?
      $past(virtual_switch_value_out) : 8'h00)) else $error("mode select");
endmodule
bind opc_object_bank opc_object_bank_checker u_chk (.*);

// ===== opc_object_bank_tb.sv
// Self-checking bench for the object bank
`timescale 1ns/1ns
module opc_object_bank_tb;
   import opc_pkg::*;
   logic clk, rstn, req, wr, ack, abt, mon;
   logic [15:0] idx;
   logic [7:0] sub, sel, en, sw;
   logic [31:0] wd, rd, code, pw, lg, bd, mt, ct;
   logic [2:0] sz;
   logic [4:0] sv;
   int error_cnt, checked, cyc;
   opc_object_bank u_dut (.sys_clk_in(clk), .resetn_in(rstn), .req_in(req),
      .write_in(wr), .index_in(idx), .subindex_in(sub), .wdata_in(wd),
      .ack_out(ack), .rdata_out(rd), .size_out(sz), .abort_out(abt),
      .abort_code_out(code), .sample_valid_in(sv),
      .power_supply_rail_mv_in(pw), .logic_supply_rail_mv_in(lg),
      .control_board_temp_in(bd), .motor_temp_in(mt), .chip_temp_in(ct),
      .special_modes_on_out(mon), .drive_mode_select_out(sel),
      .drive_mode_enable_out(en), .virtual_switch_value_out(sw));
   opc_master_model u_mst (.sys_clk_in(clk), .ack_in(ack), .req_out(req),
      .write_out(wr), .index_out(idx), .sub_out(sub), .wdata_out(wd));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
                      input logic [31:0] d, input logic [31:0] c);
      u_mst.access(w, i, s, d);
      check({31'h0, abt}, {31'h0, c != OPC_ABORT_NONE});
      check(code, c);
   endtask
   task automatic rd_chk(input logic [15:0] i, input logic [7:0] s,
                         input logic [31:0] e, input logic [2:0] z);
      acc(1'b0, i, s, 32'h0, OPC_ABORT_NONE);
      check(rd, e);
      check({29'h0, sz}, {29'h0, z});
   endtask
   task automatic t_telemetry;
      logic [31:0] v [5];
      for (int k = 0; k < 2; k++) begin
         for (int e = 0; e < 5; e++) begin
            v[e] = k ? 32'(1000 * e + 12000) : 32'hffff_ff00 - 32'(e);
         end
         @(posedge clk);
         {pw, lg, bd, mt, ct} <= {v[0], v[1], v[2], v[3], v[4]};
         sv <= 5'h1f;
         @(posedge clk);
         sv <= 5'h00;
         {pw, lg, bd, mt, ct} <= ~{v[0], v[1], v[2], v[3], v[4]};
         for (int e = 0; e < 5; e++) begin
            rd_chk(OPC_IDX_CONDITIONS, 8'(e + 1), v[e], 3'h4);
         end
      end
   endtask
   task automatic t_modes;
      logic [7:0] ev [4] = '{8'h02, 8'h01, 8'h00, 8'h02};
      logic [7:0] sv8 [4] = '{8'h07, 8'h33, 8'h5a, 8'hc3};
      for (int k = 0; k < 4; k++) begin
         acc(1'b1, OPC_IDX_DRIVE_MODES, 8'h02,
            {24'ha5a5a5, sv8[k]}, 0);
         acc(1'b1, OPC_IDX_DRIVE_MODES, 8'h01,
            {24'h5a5a5a, ev[k]}, 0);
         @(negedge clk);
         check({24'h0, en}, {24'h0, ev[k]});
         check({24'h0, sw}, {24'h0, sv8[k]});
         check({31'h0, mon}, {31'h0, ev[k] == 8'h02});
         check({24'h0, sel}, ev[k] == 8'h02 ? sv8[k] : 32'h0);
         rd_chk(OPC_IDX_DRIVE_MODES, 8'h02, {24'h0, sv8[k]}, 3'h1);
         rd_chk(OPC_IDX_DRIVE_MODES, 8'h01, {24'h0, ev[k]}, 3'h1);
      end
   endtask
   task automatic wrap_up;
      if (error_cnt == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         wrap_up();
      end
   end
   initial begin
      rstn = 1'b0;
      {sv, pw, lg, bd, mt, ct} = '0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      rd_chk(OPC_IDX_CONDITIONS, 8'h00, 32'h5, 3'h1);
      rd_chk(OPC_IDX_CONDITIONS, 8'h01, 32'h0, 3'h4);
      rd_chk(OPC_IDX_DRIVE_MODES, 8'h00, 32'h2, 3'h1);
      rd_chk(OPC_IDX_DRIVE_MODES, 8'h01, 32'h0, 3'h1);
      rd_chk(OPC_IDX_DRIVE_MODES, 8'h02, 32'h0, 3'h1);
      t_telemetry();
      acc(1'b1, OPC_IDX_CONDITIONS, 8'h01, 32'h1234,
         OPC_ABORT_READ_ONLY);
      acc(1'b1, OPC_IDX_CONDITIONS, 8'h00, 32'h9, OPC_ABORT_READ_ONLY);
      rd_chk(OPC_IDX_CONDITIONS, 8'h01, 32'd12000, 3'h4);
      acc(1'b1, OPC_IDX_DRIVE_MODES, 8'h00, 32'h7,
         OPC_ABORT_READ_ONLY);
      acc(1'b0, 16'h4016, 8'h01, 32'h0, OPC_ABORT_NO_OBJECT);
      acc(1'b0, OPC_IDX_DRIVE_MODES, 8'h03, 32'h0,
         OPC_ABORT_NO_SUBINDEX);
      t_modes();
      wrap_up();
   end
endmodule
